// ===== core/pos_pin_output_select.sv
// Per-pin output source selector with its Wishbone register slave
//
// Behaviour
// - Bits 7 and 6 of every pin register read as zero and ignore writes.
// - The low six bits of a pin register pick the source for that pin.
// - Selections clear on power-on/brown-out reset and hold otherwise.
// - Code zero routes the pin's own port output latch on every pin.
// - Codes 0x33-0x3F, 0x19-0x1B and 0x11-0x12 are reserved, route none.
// - Serial port one uses 0x13-0x15 and serial port two 0x16-0x18.
// - SPI uses 0x1E-0x20, I2C one 0x21-0x22 and I2C two 0x23-0x24.
// - Waveform generators one to three put A to D at 0x05, 0x29, 0x2D.
// - Logic cells one to four use 0x01-0x04, capture/compare 0x09-0x0C.
// - Pulse modulators five to eight use 0x0D to 0x10 in order.
// - Comparators, timer zero, oscillator and the rest use fixed codes.
// - While the lock bit is set, pin selection writes are ignored.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps

module pos_pin_output_select (
  input  wire logic                               CORE_CLK,
  input  wire logic                               RSTN,
  input  wire logic                               SYS_RSTN,
  input  wire logic                               WB_CYC_I,
  input  wire logic                               WB_STB_I,
  input  wire logic                               WB_WE_I,
  input  wire logic [7:0]                         WB_ADR_I,
  input  wire logic [3:0]                         WB_SEL_I,
  input  wire logic [31:0]                        WB_DAT_I,
  output      logic [31:0]                        WB_DAT_O,
  output      logic                               WB_ACK_O,
  input  wire logic [pos_pkg::PIN_COUNT-1:0]      PORT_LATCH_I,
  input  wire logic [pos_pkg::SRC_TOP:1]          SRC_I,
  output      logic [pos_pkg::PIN_COUNT-1:0]      PIN_OUT,
  output      logic [pos_pkg::PIN_COUNT-1:0]      PIN_DRIVEN,
  output      logic                               LOCKED
);

  // Register state
  logic [pos_pkg::SEL_W-1:0]     sel_r    [pos_pkg::PIN_COUNT];
  logic [pos_pkg::SEL_W-1:0]     sel_nxt  [pos_pkg::PIN_COUNT];
  logic                          lock_r;
  logic                          lock_nxt;
  logic                          ack_r;
  logic                          ack_nxt;
  logic [31:0]                   rdat_r;
  logic [31:0]                   rdat_nxt;

  // Pin state
  logic [pos_pkg::PIN_COUNT-1:0] pin_out_r;
  logic [pos_pkg::PIN_COUNT-1:0] pin_out_nxt;
  logic [pos_pkg::PIN_COUNT-1:0] pin_drv_r;
  logic [pos_pkg::PIN_COUNT-1:0] pin_drv_nxt;
  logic [pos_pkg::PIN_COUNT-1:0] mux_out;
  logic [pos_pkg::PIN_COUNT-1:0] mux_drv;

  // Bus decode
  logic                          req;
  logic                          wr_fire;
  logic [5:0]                    word_idx;
  logic                          hit_pin;
  logic                          hit_lock;
  logic [2:0]                    pin_idx;

  assign req      = WB_CYC_I & WB_STB_I;
  assign wr_fire  = req & WB_WE_I & ack_r & WB_SEL_I[0];
  assign word_idx = WB_ADR_I[7:2];
  assign hit_pin  = (word_idx < pos_pkg::LOCK_IDX);
  assign hit_lock = (word_idx == pos_pkg::LOCK_IDX);
  assign pin_idx  = word_idx[2:0];

  // Acknowledge and read data, one wait state, unmapped reads give zero
  always_comb begin
    ack_nxt  = req & ~ack_r;
    rdat_nxt = rdat_r;
    if (ack_nxt) begin
      rdat_nxt = 32'h0000_0000;
      if (hit_pin) begin
        rdat_nxt[pos_pkg::SEL_W-1:0] = sel_r[pin_idx];
      end else if (hit_lock) begin
        rdat_nxt[pos_pkg::LOCK_BIT] = lock_r;
      end
    end
  end

  // Bus answer registers, cleared by any reset
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !SYS_RSTN) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Lock bit, writable on byte lane zero
  always_comb begin
    lock_nxt = lock_r;
    if (wr_fire && hit_lock) begin
      lock_nxt = WB_DAT_I[pos_pkg::LOCK_BIT];
    end
  end

  // Lock clears on every reset
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !SYS_RSTN) begin
      lock_r <= pos_pkg::LOCK_RESET;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Selection next values
  always_comb begin
    for (int i = 0; i < pos_pkg::PIN_COUNT; i++) begin
      sel_nxt[i] = sel_r[i];
      if (wr_fire && hit_pin && !lock_r && (pin_idx == 3'(i))) begin
        // six bit field, upper bits ignored
        sel_nxt[i] = WB_DAT_I[pos_pkg::SEL_W-1:0];
      end
    end
  end

  // only power-on reset clears the selection
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < pos_pkg::PIN_COUNT; i++) begin
        sel_r[i] <= pos_pkg::SEL_RESET;
      end
    end else begin
      for (int i = 0; i < pos_pkg::PIN_COUNT; i++) begin
        sel_r[i] <= sel_nxt[i];
      end
    end
  end

  // Per-pin source multiplexer
  genvar g;
  generate
    for (g = 0; g < pos_pkg::PIN_COUNT; g++) begin : g_pin
      logic [2:0] port_id;
      logic [5:0] mask;
      logic       ok;
      assign port_id = pos_pkg::PIN_PORT_MAP[3*g +: 3];
      assign mask    = pos_pkg::pos_port_mask(sel_r[g]);
      assign ok      = mask[port_id];
      always_comb begin
        mux_out[g] = 1'b0;
        mux_drv[g] = ok;
        if (ok) begin
          if (sel_r[g] == pos_pkg::SRC_LATCH) begin
            mux_out[g] = PORT_LATCH_I[g];
          end else begin
            mux_out[g] = SRC_I[sel_r[g]];
          end
        end
      end
    end
  endgenerate

  // Pin output next values
  always_comb begin
    pin_out_nxt = mux_out;
    pin_drv_nxt = mux_drv;
  end

  // Pin outputs registered
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pin_out_r <= '0;
      pin_drv_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_drv_r <= pin_drv_nxt;
    end
  end

  assign WB_ACK_O   = ack_r;
  assign WB_DAT_O   = rdat_r;
  assign PIN_OUT    = pin_out_r;
  assign PIN_DRIVEN = pin_drv_r;
  assign LOCKED     = lock_r;

  // Checks on the selector
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  AST_UPPER_ZERO: assert property (
    (req && !WB_WE_I && !ack_r && hit_pin) |=> (WB_DAT_O[31:6] == 26'h0))
    else $error("pin register upper bits not zero");

  AST_WRITE_STORES: assert property (
    (wr_fire && hit_pin && !lock_r && SYS_RSTN && pin_idx == 3'h0)
      |=> (sel_r[0] == $past(WB_DAT_I[5:0])))
    else $error("selection write not stored");

  AST_OTHER_RESET_KEEPS: assert property (
    (!SYS_RSTN && !wr_fire) |=> (sel_r[0] == $past(sel_r[0])))
    else $error("selection lost on other reset");

  AST_LATCH_DEFAULT: assert property (
    (sel_r[3] == pos_pkg::SRC_LATCH)
      |=> (PIN_DRIVEN[3] && PIN_OUT[3] == $past(PORT_LATCH_I[3])))
    else $error("latch not routed on code zero");

  AST_RESERVED_UNDRIVEN: assert property (
    (sel_r[4] >= pos_pkg::SRC_RESV_LOW) |=> !PIN_DRIVEN[4] && !PIN_OUT[4])
    else $error("reserved code drives pin");

  AST_UART_TX: assert property (
    (sel_r[2] == pos_pkg::SRC_UART1_TX)
      |=> (PIN_OUT[2] == $past(SRC_I[19])))
    else $error("serial transmit misrouted");

  AST_SPI_CLOCK: assert property (
    (sel_r[1] == pos_pkg::SRC_SPI_SCK) ##1 1'b1
      |-> (PIN_OUT[1] == $past(SRC_I[30])) && PIN_DRIVEN[1])
    else $error("spi clock misrouted");

  AST_WAVE_A: assert property (
    (sel_r[2] == pos_pkg::SRC_WAVE1_A) |=> (PIN_OUT[2] == $past(SRC_I[5])))
    else $error("waveform output misrouted");

  AST_LOGIC_CELL: assert property (
    (sel_r[0] == pos_pkg::SRC_LOGIC1) |=> (PIN_OUT[0] == $past(SRC_I[1])))
    else $error("logic cell misrouted");

  AST_PWM_EIGHT: assert property (
    (sel_r[3] == pos_pkg::SRC_PULSE8) |=> (PIN_OUT[3] == $past(SRC_I[16])))
    else $error("pulse modulator misrouted");

  AST_COMPARATOR: assert property (
    (sel_r[0] == pos_pkg::SRC_CMP1) |=> (PIN_OUT[0] == $past(SRC_I[28])))
    else $error("comparator misrouted");

  AST_PORT_UNAVAILABLE: assert property (
    (sel_r[2] == pos_pkg::SRC_GUARD_B) |=> !PIN_DRIVEN[2])
    else $error("unavailable code drives pin");

  AST_LOCK_BLOCKS: assert property (
    (lock_r && wr_fire && hit_pin && pin_idx == 3'h0)
      |=> (sel_r[0] == $past(sel_r[0])))
    else $error("locked write changed selection");

  // Bus side: one wait state, one-cycle answer, read back of the fields
  AST_ACK_FOLLOWS: assert property (
    (req && !ack_r && SYS_RSTN) |=> WB_ACK_O)
    else $error("request not acknowledged");

  AST_ACK_PULSE: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");

  AST_READ_SELECT: assert property (
    (req && !WB_WE_I && !ack_r && hit_pin && pin_idx == 3'h0 && SYS_RSTN)
      |=> (WB_DAT_O[5:0] == $past(sel_r[0])))
    else $error("selection read back wrong");

  AST_LOCK_READ_ZERO: assert property (
    (req && !WB_WE_I && !ack_r && hit_lock) |=> (WB_DAT_O[31:1] == 31'h0))
    else $error("lock register upper bits not zero");

  AST_FIELD_MASKED: assert property (
    (wr_fire && hit_pin && !lock_r && pin_idx == 3'h3)
      |=> (sel_r[3] == $past(WB_DAT_I[5:0])))
    else $error("pin three write not stored");

  AST_LANE_IGNORED: assert property (
    (req && WB_WE_I && ack_r && !WB_SEL_I[0] && hit_pin && pin_idx == 3'h3)
      |=> (sel_r[3] == $past(sel_r[3])))
    else $error("write without low lane changed selection");

  AST_HOLD_UNWRITTEN: assert property (
    !(wr_fire && hit_pin && pin_idx == 3'h1)
      |=> (sel_r[1] == $past(sel_r[1])))
    else $error("selection changed without a write");

  AST_LOCK_WRITE: assert property (
    (wr_fire && hit_lock && SYS_RSTN) |=> (LOCKED == $past(WB_DAT_I[0])))
    else $error("lock bit write not stored");

  AST_LOCK_SYS_CLEAR: assert property (
    !SYS_RSTN |=> !LOCKED)
    else $error("lock bit kept over reset");

  // Pin side: further codes on pins whose port offers them or not
  AST_UART2_RTS: assert property (
    (sel_r[1] == pos_pkg::SRC_UART2_RTS)
      |=> (PIN_DRIVEN[1] && PIN_OUT[1] == $past(SRC_I[24])))
    else $error("serial request-to-send misrouted");

  AST_SPI_SELECT: assert property (
    (sel_r[3] == pos_pkg::SRC_SPI_SS)
      |=> (PIN_DRIVEN[3] && PIN_OUT[3] == $past(SRC_I[32])))
    else $error("spi select misrouted");

  AST_WAVE2_A: assert property (
    (sel_r[1] == pos_pkg::SRC_WAVE2_A)
      |=> (PIN_DRIVEN[1] && PIN_OUT[1] == $past(SRC_I[41])))
    else $error("second waveform output misrouted");

  AST_CAPCMP_ONE: assert property (
    (sel_r[5] == pos_pkg::SRC_CAPCMP1)
      |=> (PIN_DRIVEN[5] && PIN_OUT[5] == $past(SRC_I[9])))
    else $error("capture compare misrouted");

  AST_PWM_FIVE: assert property (
    (sel_r[6] == pos_pkg::SRC_PULSE5)
      |=> (PIN_DRIVEN[6] && PIN_OUT[6] == $past(SRC_I[13])))
    else $error("pulse modulator five misrouted");

  AST_TIMER_ZERO: assert property (
    (sel_r[5] == pos_pkg::SRC_TIMER0)
      |=> (PIN_DRIVEN[5] && PIN_OUT[5] == $past(SRC_I[37])))
    else $error("timer output misrouted");

  AST_GUARD_B: assert property (
    (sel_r[0] == pos_pkg::SRC_GUARD_B)
      |=> (PIN_DRIVEN[0] && PIN_OUT[0] == $past(SRC_I[50])))
    else $error("guard ring output misrouted");

  AST_RESERVED_MID: assert property (
    (sel_r[0] >= 6'h19 && sel_r[0] <= 6'h1B)
      |=> (!PIN_DRIVEN[0] && !PIN_OUT[0]))
    else $error("middle reserved code drives pin");

  AST_RESERVED_LOW: assert property (
    ((sel_r[0] == 6'h11) || (sel_r[0] == 6'h12))
      |=> (!PIN_DRIVEN[0] && !PIN_OUT[0]))
    else $error("low reserved code drives pin");

  AST_LATCH_PIN1: assert property (
    (sel_r[1] == pos_pkg::SRC_LATCH)
      |=> (PIN_DRIVEN[1] && PIN_OUT[1] == $past(PORT_LATCH_I[1])))
    else $error("latch not routed on pin one");

  AST_UNAVAIL_SERIAL: assert property (
    (sel_r[0] == pos_pkg::SRC_UART1_TX)
      |=> (!PIN_DRIVEN[0] && !PIN_OUT[0]))
    else $error("serial code drives pin without it");

  COV_WRITE_PIN: cover property (wr_fire && hit_pin && !lock_r);
  COV_SYS_RESET: cover property (!SYS_RSTN && lock_r);
  COV_LOCKED_WRITE: cover property (wr_fire && hit_pin && lock_r);
  COV_PERIPH_DRIVE: cover property (PIN_DRIVEN[2] && sel_r[2] != 6'h00);
  COV_READ_LOCK: cover property (req && !WB_WE_I && hit_lock && ack_r);

endmodule

// ===== core/pos_pkg.sv
// Constants, source codes and availability table for the pin output selector
package pos_pkg;

  // Geometry of the selector
  localparam int          PIN_COUNT  = 8;
  localparam int          SEL_W      = 6;
  localparam int          REG_W      = 8;
  localparam int          SRC_TOP    = 50;

  // Register map, byte addresses and word indices on the Wishbone slave
  localparam logic [7:0]  PIN_SEL_BASE = 8'h00;
  localparam logic [7:0]  LOCK_ADDR    = 8'h20;
  localparam logic [5:0]  PIN_SEL_IDX  = 6'h00;
  localparam logic [5:0]  LOCK_IDX     = 6'h08;
  localparam int          LOCK_BIT     = 0;

  // Values after reset
  localparam logic [5:0]  SEL_RESET  = 6'h00;
  localparam logic        LOCK_RESET = 1'b0;

  // Port identities
  localparam logic [2:0]  PORT_A = 3'h0;
  localparam logic [2:0]  PORT_B = 3'h1;
  localparam logic [2:0]  PORT_C = 3'h2;
  localparam logic [2:0]  PORT_D = 3'h3;
  localparam logic [2:0]  PORT_E = 3'h4;
  localparam logic [2:0]  PORT_F = 3'h5;

  // Port of each pin, pin 0 in the low bits
  localparam logic [23:0] PIN_PORT_MAP = {PORT_C, PORT_A, PORT_F, PORT_E,
                                          PORT_D, PORT_C, PORT_B, PORT_A};

  // Source selection codes
  localparam logic [5:0]  SRC_LATCH      = 6'h00;
  localparam logic [5:0]  SRC_LOGIC1     = 6'h01;
  localparam logic [5:0]  SRC_LOGIC2     = 6'h02;
  localparam logic [5:0]  SRC_LOGIC3     = 6'h03;
  localparam logic [5:0]  SRC_LOGIC4     = 6'h04;
  localparam logic [5:0]  SRC_WAVE1_A    = 6'h05;
  localparam logic [5:0]  SRC_WAVE1_D    = 6'h08;
  localparam logic [5:0]  SRC_CAPCMP1    = 6'h09;
  localparam logic [5:0]  SRC_CAPCMP4    = 6'h0C;
  localparam logic [5:0]  SRC_PULSE5     = 6'h0D;
  localparam logic [5:0]  SRC_PULSE6     = 6'h0E;
  localparam logic [5:0]  SRC_PULSE7     = 6'h0F;
  localparam logic [5:0]  SRC_PULSE8     = 6'h10;
  localparam logic [5:0]  SRC_UART1_TX   = 6'h13;
  localparam logic [5:0]  SRC_UART1_DE   = 6'h14;
  localparam logic [5:0]  SRC_UART1_RTS  = 6'h15;
  localparam logic [5:0]  SRC_UART2_TX   = 6'h16;
  localparam logic [5:0]  SRC_UART2_DE   = 6'h17;
  localparam logic [5:0]  SRC_UART2_RTS  = 6'h18;
  localparam logic [5:0]  SRC_CMP1       = 6'h1C;
  localparam logic [5:0]  SRC_CMP2       = 6'h1D;
  localparam logic [5:0]  SRC_SPI_SCK    = 6'h1E;
  localparam logic [5:0]  SRC_SPI_SDO    = 6'h1F;
  localparam logic [5:0]  SRC_SPI_SS     = 6'h20;
  localparam logic [5:0]  SRC_I2C1_SCL   = 6'h21;
  localparam logic [5:0]  SRC_I2C1_SDA   = 6'h22;
  localparam logic [5:0]  SRC_I2C2_SCL   = 6'h23;
  localparam logic [5:0]  SRC_I2C2_SDA   = 6'h24;
  localparam logic [5:0]  SRC_TIMER0     = 6'h25;
  localparam logic [5:0]  SRC_NCO        = 6'h26;
  localparam logic [5:0]  SRC_CLKREF     = 6'h27;
  localparam logic [5:0]  SRC_MODULATOR  = 6'h28;
  localparam logic [5:0]  SRC_WAVE2_A    = 6'h29;
  localparam logic [5:0]  SRC_WAVE2_D    = 6'h2C;
  localparam logic [5:0]  SRC_WAVE3_A    = 6'h2D;
  localparam logic [5:0]  SRC_WAVE3_B    = 6'h2E;
  localparam logic [5:0]  SRC_WAVE3_D    = 6'h30;
  localparam logic [5:0]  SRC_GUARD_A    = 6'h31;
  localparam logic [5:0]  SRC_GUARD_B    = 6'h32;
  localparam logic [5:0]  SRC_RESV_LOW   = 6'h33;

  // Ports that may carry a code, one bit per port, F down to A
  function automatic logic [5:0] pos_port_mask(logic [5:0] code);
    logic [5:0] m;
    m = 6'h00;
    case (code)
      SRC_LATCH:                               m = 6'h3F;
      SRC_LOGIC1, SRC_LOGIC2:                  m = 6'h21;
      SRC_LOGIC3, SRC_LOGIC4:                  m = 6'h0A;
      SRC_WAVE1_A:                             m = 6'h06;
      6'h06, 6'h07, SRC_WAVE1_D:               m = 6'h0A;
      SRC_CAPCMP1, 6'h0A:                      m = 6'h24;
      6'h0B, SRC_CAPCMP4:                      m = 6'h0A;
      SRC_PULSE5:                              m = 6'h21;
      SRC_PULSE6, SRC_PULSE8:                  m = 6'h09;
      SRC_PULSE7:                              m = 6'h24;
      SRC_UART1_TX, SRC_UART1_DE, SRC_UART1_RTS: m = 6'h24;
      SRC_UART2_TX, SRC_UART2_DE, SRC_UART2_RTS: m = 6'h0A;
      SRC_CMP1:                                m = 6'h09;
      SRC_CMP2:                                m = 6'h11;
      SRC_SPI_SCK, SRC_SPI_SDO:                m = 6'h06;
      SRC_SPI_SS:                              m = 6'h09;
      SRC_I2C1_SCL, SRC_I2C1_SDA:              m = 6'h06;
      SRC_I2C2_SCL, SRC_I2C2_SDA:              m = 6'h0A;
      SRC_TIMER0:                              m = 6'h24;
      SRC_NCO, SRC_MODULATOR:                  m = 6'h09;
      SRC_CLKREF:                              m = 6'h12;
      SRC_WAVE2_A, SRC_WAVE3_A:                m = 6'h06;
      6'h2A, 6'h2B, SRC_WAVE2_D:               m = 6'h0A;
      SRC_WAVE3_B:                             m = 6'h11;
      6'h2F, SRC_WAVE3_D:                      m = 6'h09;
      SRC_GUARD_A, SRC_GUARD_B:                m = 6'h21;
      default:                                 m = 6'h00;
    endcase
    return m;
  endfunction

endpackage

// ===== verification/pos_src_model.sv
// Far-side model: peripheral outputs and port latches feeding the selector
`timescale 1ns/1ps

module pos_src_model (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RSTN,
  output      logic [pos_pkg::SRC_TOP:1] SRC,
  output      logic [7:0]                LATCH
);
  logic [pos_pkg::SRC_TOP:1] src_r;
  logic [7:0]                lat_r;

  // Every source keeps moving so a wrong route shows up quickly
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      src_r <= 50'h2_5A5A_C3C3_F0F1;
      lat_r <= 8'h5A;
    end else begin
      src_r <= {src_r[49:1], src_r[50] ^ src_r[41]};
      lat_r <= lat_r + 8'h25;
    end
  end

  // Outputs straight from the pattern registers
  assign SRC   = src_r;
  assign LATCH = lat_r;
endmodule

// ===== verification/pos_pin_output_select_test.sv
// Self-checking bench for the pin output source selector
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module pos_pin_output_select_test;
  logic                      clk, rstn, sys_rstn, cyc, stb, we, ack, locked;
  logic [7:0]                adr, lat, pin_out, pin_drv;
  logic [3:0]                sel;
  logic [31:0]               dat_i, dat_o, rd;
  logic [pos_pkg::SRC_TOP:1] src;
  int                        failures, check_count, cycles;
  // Pin, driven flag and code per entry: 16'hPDCC
  logic [15:0] routes [32] = '{16'h0101, 16'h1001, 16'h1104, 16'h2105,
    16'h5109, 16'h310C, 16'h010D, 16'h3110, 16'h2113, 16'h1118, 16'h011C,
    16'h411D, 16'h111E, 16'h3120, 16'h1124, 16'h5125, 16'h4127, 16'h0128,
    16'h1129, 16'h412E, 16'h3130, 16'h0132, 16'h2032, 16'h0011, 16'h0019,
    16'h301B, 16'h4033, 16'h1100, 16'h610D, 16'h7113, 16'h0013, 16'h2121};

  pos_src_model pos_src_model_i (.CORE_CLK(clk), .RSTN(rstn), .SRC(src),
    .LATCH(lat));

  pos_pin_output_select pos_pin_output_select_i (.CORE_CLK(clk),
    .RSTN(rstn), .SYS_RSTN(sys_rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PORT_LATCH_I(lat), .SRC_I(src),
    .PIN_OUT(pin_out), .PIN_DRIVEN(pin_drv), .LOCKED(locked));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  // One classic Wishbone cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
          input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rreg(input logic [7:0] a);
    wb(1'b0, a, 8'h00, 4'hF);
  endtask

  // Select a code on a pin and judge the pin one cycle behind the source
  task route(input logic [15:0] e);
    logic [2:0] p;
    logic       dv;
    logic [5:0] c;
    logic       x;
    p = e[14:12];
    dv = e[8];
    c = e[5:0];
    wb(1'b1, {3'b000, p, 2'b00}, {2'b00, c}, 4'hF);
    repeat (3) @(negedge clk);
    x = !dv ? 1'b0 : (c == 6'h00) ? lat[p] : src[c];
    @(negedge clk);
    `CHK(pin_drv[p], dv)
    `CHK(pin_out[p], x)
  endtask

  task t_routes();
    foreach (routes[i]) begin
      route(routes[i]);
    end
  endtask

  task t_reset();
    logic [7:0] x;
    for (int i = 0; i < 8; i++) begin
      rreg(8'(4 * i));
      `CHK(rd, 32'h00000000)
    end
    rreg(pos_pkg::LOCK_ADDR);
    `CHK(rd, 32'h00000000)
    @(negedge clk);
    x = lat;
    @(negedge clk);
    `CHK(pin_drv, 8'hFF)
    `CHK(pin_out, x)
  endtask

  task t_field();
    wb(1'b1, 8'h0C, 8'hFF, 4'hF);
    rreg(8'h0C);
    `CHK(rd, 32'h0000003F)
    wb(1'b1, 8'h0C, 8'h05, 4'hE);
    rreg(8'h0C);
    `CHK(rd, 32'h0000003F)
    wb(1'b1, 8'h24, 8'h01, 4'hF);
    rreg(8'h24);
    `CHK(rd, 32'h00000000)
  endtask

  task t_lock();
    wb(1'b1, 8'h00, 8'h1C, 4'hF);
    wb(1'b1, pos_pkg::LOCK_ADDR, 8'h01, 4'hF);
    @(negedge clk);
    `CHK(locked, 1'b1)
    wb(1'b1, 8'h00, 8'h0D, 4'hF);
    rreg(8'h00);
    `CHK(rd, 32'h0000001C)
    wb(1'b1, pos_pkg::LOCK_ADDR, 8'h00, 4'hF);
    wb(1'b1, 8'h00, 8'h0D, 4'hF);
    rreg(8'h00);
    `CHK(rd, 32'h0000000D)
  endtask

  // Other resets keep the selection, power-on reset clears it
  task t_resets();
    wb(1'b1, pos_pkg::LOCK_ADDR, 8'h01, 4'hF);
    @(posedge clk);
    sys_rstn <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rstn <= 1'b1;
    rreg(8'h00);
    `CHK(rd, 32'h0000000D)
    `CHK(locked, 1'b0)
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rreg(8'h00);
    `CHK(rd, 32'h00000000)
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    sys_rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_i = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    sys_rstn <= 1'b1;
    t_reset();
    t_field();
    t_routes();
    t_lock();
    t_resets();
    report_and_stop();
  end
endmodule
